//--- design/sscf_map.vh
// Purpose: Addresses, bit positions, reset values and timing of the SPI status/control block
// Assumes: 8-bit special function register space, page 0x0
// Notes: Configuration register address is not fixed by the port's own map; see parameters
`ifndef SSCF_MAP_VH
`define SSCF_MAP_VH
`define SSCF_ADDR_CTRL 8'hF8
`define SSCF_ADDR_CFG 8'hA1
`define SSCF_ADDR_DATA 8'hA3
`define SSCF_ADDR_RATE 8'hA2
`define SSCF_PAGE 4'h0
`define SSCF_CTRL_RESET 8'h06
`define SSCF_CFG_RESET 8'h07
`define SSCF_RATE_RESET 8'h00
`define SSCF_B_DONE 7
`define SSCF_B_WRITE_COLLISION_FLAG 6
`define SSCF_B_MODE_FAULT_FLAG 5
`define SSCF_B_OVRN 4
`define SSCF_B_SMD1 3
`define SSCF_B_SMD0 2
`define SSCF_B_TXE 1
`define SSCF_B_EN 0
`define SSCF_B_BUSY 7
`define SSCF_B_MST 6
`define SSCF_B_PHA 5
`define SSCF_B_POL 4
`define SSCF_B_SLV 3
`define SSCF_B_RAW 2
`define SSCF_B_SRE 1
`define SSCF_B_RXE 0
`define SSCF_SMD_3WIRE 2'h0
`define SSCF_SMD_4SLAVE 2'h1
`define SSCF_DEGLITCH_CYCLES 3'h3
`endif

//--- design/sscf_deglitch.v
// Purpose: Two-flop synchroniser followed by a stability filter
// Assumes: Input is asynchronous to clk
// Notes: Output changes only after the synced level holds for the full count
`timescale 1ns/1ps
`default_nettype none
module sscf_deglitch #(
	parameter [2:0] COUNT = 3'h3,
	parameter RESET_VAL = 1'b1
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Signal
	input wire din,
	output wire sync_out,
	output reg clean_q
);
	reg s1_q;
	reg s2_q;
	reg [2:0] cnt_q;
	assign sync_out = s2_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			cnt_q <= 3'h0;
			clean_q <= RESET_VAL;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			if (s2_q == clean_q) begin
				cnt_q <= 3'h0;
			end else if (cnt_q == COUNT) begin
				clean_q <= s2_q;
				cnt_q <= 3'h0;
			end else begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- design/sscf_port.v
// Purpose: SPI port with status flags, select modes and SFR access
// Assumes: Single-cycle SFR bus on clk; pins pass two flops before use
// Notes: Bit writes use a set/clear strobe pair for bit-addressable control
// How it works
// - Polarity one: clock line idles high.
// - Selected flag is one while de-glitched select is low.
// - Raw select bit returns undebounced pin level on read.
// - Slave shift-empty sets after shifting done, clears on load or clock edge.
// - Master: shift-empty reads one.
// - Slave receive-empty sets once buffer read, clears on unread data.
// - Master: receive-empty reads one.
// - Slave samples mid-bit; master samples one clock before bit end.
// - Transfer-done set at end of each byte; requests interrupt.
// - Data write while transmit full sets collision and is dropped.
// - Mode fault when select low, master, select mode 01.
// - Slave overrun when last bit arrives with receive buffer unread.
// - Four flags request interrupt, never self-clear, software clears.
// - Select mode 00: three-wire, select pin unused.
// - Select mode 01 (reset): four-wire slave, select is input.
// - Select mode 1x: select driven to field low bit.
// - Transmit-empty clears on data write, sets when loaded to shifter.
// - Control register at 0xF8 page 0 with bit set and clear.
// - Polarity zero: clock line idles low.
// - Slave: phase zero samples first edge; one samples second edge.
// - Master enable zero slave, one master.
// - Busy reads one during any byte transfer.
`timescale 1ns/1ps
`default_nettype none
`include "sscf_map.vh"
module sscf_port #(
	parameter [7:0] CFG_ADDR = `SSCF_ADDR_CFG,
	parameter [7:0] DATA_ADDR = `SSCF_ADDR_DATA,
	parameter [7:0] RATE_ADDR = `SSCF_ADDR_RATE
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Special function register bus
	input wire [3:0] sfr_page,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	input wire sfr_rd,
	input wire sfr_bit_set,
	input wire sfr_bit_clr,
	input wire [2:0] sfr_bit,
	output reg [7:0] sfr_rdata_q,
	output reg irq_q,
	// Serial pins
	input wire sck_in,
	output reg sck_out_q,
	output reg sck_oe_n_q,
	input wire mosi_in,
	output reg mosi_out_q,
	output reg mosi_oe_n_q,
	input wire miso_in,
	output reg miso_out_q,
	output reg miso_oe_n_q,
	input wire slave_select_line_in,
	output reg slave_select_line_out_q,
	output reg slave_select_line_oe_n_q
);
	reg [7:0] ctl_q;
	reg mst_q, pha_q, pol_q;
	reg [7:0] rate_q, tx_q, rx_q, sh_q;
	reg txe_q, rxe_q, sre_q, busy_q;
	reg [2:0] bitn_q;
	reg [8:0] div_q;
	reg edge_q;
	reg sck_s1_q, sck_s2_q, sck_p_q, mosi_s1_q, mosi_s2_q, miso_s1_q, miso_s2_q;
	wire sel_sync, sel_clean;
	wire en = ctl_q[`SSCF_B_EN];
	wire [1:0] smd = ctl_q[`SSCF_B_SMD1:`SSCF_B_SMD0];
	wire pg = (sfr_page == `SSCF_PAGE);
	wire ctl_hit = pg && (sfr_addr == `SSCF_ADDR_CTRL);
	wire dat_wr = pg && sfr_wr && (sfr_addr == DATA_ADDR);
	wire dat_rd = pg && sfr_rd && (sfr_addr == DATA_ADDR);
	sscf_deglitch #(.COUNT(`SSCF_DEGLITCH_CYCLES), .RESET_VAL(1'b1)) u_sel (
		.clk(clk),
		.rst_n(rst_n),
		.din(slave_select_line_in),
		.sync_out(sel_sync),
		.clean_q(sel_clean)
	);
	// Slave is selected in 3-wire mode always; 4-wire uses the filtered pin
	wire slv_sel = (smd == `SSCF_SMD_3WIRE) ? 1'b1 : !sel_clean;
	wire slv_act = en && !mst_q && slv_sel;
	wire sck_n = sck_s2_q ^ pol_q;
	wire sck_rise = sck_s2_q && !sck_p_q;
	wire sck_fall = !sck_s2_q && sck_p_q;
	wire lead = pol_q ? sck_fall : sck_rise;
	wire trail = pol_q ? sck_rise : sck_fall;
	// Phase 0 samples leading edge, phase 1 the trailing edge
	wire s_samp = slv_act && (pha_q ? trail : lead);
	wire s_shft = slv_act && (pha_q ? lead : trail) && busy_q;
	// Besides a slave load, only a leading edge opens a byte; the trailing edge of the last bit must not
	wire s_edge = slv_act && lead;
	// Master half bit is rate+1 clocks; sample one clock before bit end
	wire [8:0] half = {1'b0, rate_q} + 9'h1;
	wire m_tick = busy_q && mst_q && (div_q == half - 9'h1);
	wire m_samp = busy_q && mst_q && edge_q && (div_q == half - 9'h2);
	wire last_sample = s_samp && (bitn_q == 3'h7);
	wire m_end = m_tick && edge_q && (bitn_q == 3'h7);
	wire byte_end = last_sample || m_end;
	// Byte transfers by either side set transmit-empty when loaded
	wire m_start = en && mst_q && !busy_q && !txe_q;
	wire s_load = slv_act && !busy_q && !txe_q;
	wire set_done = byte_end;
	wire set_write_collision_flag = dat_wr && !txe_q;
	wire set_mode_fault_flag = en && mst_q && (smd == `SSCF_SMD_4SLAVE) && !sel_clean;
	wire set_ovrn = last_sample && !rxe_q && !mst_q;
	wire [7:0] sets = {set_done, set_write_collision_flag, set_mode_fault_flag, set_ovrn, 4'h0};
	wire [7:0] cfg_rd = {busy_q, mst_q, pha_q, pol_q, !sel_clean,
		sel_sync, mst_q ? 1'b1 : sre_q, mst_q ? 1'b1 : rxe_q};
	reg [7:0] ctl_d;
	always @* begin
		ctl_d = ctl_q;
		if (ctl_hit && sfr_wr) begin
			ctl_d = sfr_wdata;
		end else if (ctl_hit && sfr_bit_set) begin
			ctl_d[sfr_bit] = 1'b1;
		end else if (ctl_hit && sfr_bit_clr) begin
			ctl_d[sfr_bit] = 1'b0;
		end
		// Hardware set wins over a software clear in the same cycle
		ctl_d = ctl_d | sets;
		ctl_d[`SSCF_B_TXE] = txe_q;
	end
	// Pin synchronisers: only the second flop reads the first
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_p_q <= 1'b0;
			mosi_s1_q <= 1'b0;
			mosi_s2_q <= 1'b0;
			miso_s1_q <= 1'b0;
			miso_s2_q <= 1'b0;
		end else begin
			sck_s1_q <= sck_in;
			sck_s2_q <= sck_s1_q;
			sck_p_q <= sck_s2_q;
			mosi_s1_q <= mosi_in;
			mosi_s2_q <= mosi_s1_q;
			miso_s1_q <= miso_in;
			miso_s2_q <= miso_s1_q;
		end
	end
	// Control flags and the request line
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= `SSCF_CTRL_RESET;
			irq_q <= 1'b0;
		end else begin
			ctl_q <= ctl_d;
			irq_q <= |(ctl_d[`SSCF_B_DONE:`SSCF_B_OVRN]);
		end
	end
	// Configuration and rate; change these only while the port is disabled
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mst_q <= 1'b0;
			pha_q <= 1'b0;
			pol_q <= 1'b0;
			rate_q <= `SSCF_RATE_RESET;
		end else begin
			if (pg && sfr_wr && sfr_addr == CFG_ADDR) begin
				mst_q <= sfr_wdata[`SSCF_B_MST];
				pha_q <= sfr_wdata[`SSCF_B_PHA];
				pol_q <= sfr_wdata[`SSCF_B_POL];
			end
			if (pg && sfr_wr && sfr_addr == RATE_ADDR) begin
				rate_q <= sfr_wdata;
			end
		end
	end
	// Read data is registered and stands until the next read
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_rd && pg) begin
			case (sfr_addr)
				`SSCF_ADDR_CTRL: begin
					sfr_rdata_q <= ctl_q;
				end
				CFG_ADDR: begin
					sfr_rdata_q <= cfg_rd;
				end
				DATA_ADDR: begin
					sfr_rdata_q <= rx_q;
				end
				RATE_ADDR: begin
					sfr_rdata_q <= rate_q;
				end
				default: begin
					sfr_rdata_q <= 8'h00;
				end
			endcase
		end
	end
	// Transfer engine: buffers, shifter, bit and half-bit counters
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			sh_q <= 8'h00;
			txe_q <= 1'b1;
			rxe_q <= 1'b1;
			sre_q <= 1'b1;
			busy_q <= 1'b0;
			bitn_q <= 3'h0;
			div_q <= 9'h000;
			edge_q <= 1'b0;
		end else begin
			if (dat_wr && txe_q) begin
				tx_q <= sfr_wdata;
				txe_q <= 1'b0;
			end
			if (m_start || s_load) begin
				sh_q <= tx_q;
				txe_q <= 1'b1;
				sre_q <= 1'b0;
				busy_q <= 1'b1;
				bitn_q <= 3'h0;
				div_q <= 9'h000;
				edge_q <= 1'b0;
			end else if (s_edge) begin
				sre_q <= 1'b0;
				busy_q <= 1'b1;
			end
			if (busy_q && mst_q) begin
				div_q <= m_tick ? 9'h000 : div_q + 9'h1;
				if (m_tick) begin
					edge_q <= !edge_q;
				end
				if (m_samp) begin
					sh_q <= {sh_q[6:0], miso_s2_q};
				end
				if (m_tick && edge_q) begin
					bitn_q <= bitn_q + 3'h1;
				end
			end
			if (s_samp) begin
				sh_q <= {sh_q[6:0], mosi_s2_q};
				bitn_q <= bitn_q + 3'h1;
			end
			if (byte_end) begin
				rx_q <= s_samp ? {sh_q[6:0], mosi_s2_q} : sh_q;
				rxe_q <= 1'b0;
				busy_q <= 1'b0;
				sre_q <= txe_q;
			end else if (dat_rd) begin
				rxe_q <= 1'b1;
			end
			if (!en || (!mst_q && !slv_sel && !busy_q)) begin
				busy_q <= 1'b0;
				bitn_q <= 3'h0;
			end
		end
	end
	// Pin drivers; all released at reset
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_out_q <= 1'b0;
			sck_oe_n_q <= 1'b1;
			mosi_out_q <= 1'b0;
			mosi_oe_n_q <= 1'b1;
			miso_out_q <= 1'b0;
			miso_oe_n_q <= 1'b1;
			slave_select_line_out_q <= 1'b1;
			slave_select_line_oe_n_q <= 1'b1;
		end else begin
			// Phase 0 is active in the second half bit, so the first edge falls mid-bit
			sck_out_q <= pol_q ^ (busy_q && mst_q && (edge_q ^ pha_q));
			sck_oe_n_q <= !(en && mst_q);
			mosi_out_q <= sh_q[7];
			mosi_oe_n_q <= !(en && mst_q);
			miso_out_q <= sh_q[7];
			miso_oe_n_q <= !slv_act;
			slave_select_line_out_q <= ctl_q[`SSCF_B_SMD0];
			slave_select_line_oe_n_q <= !(en && ctl_q[`SSCF_B_SMD1]);
		end
	end
	wire unused = sck_n ^ s_shft;
endmodule
`default_nettype wire

//--- bench/sscf_port_props.sv
// Purpose: Port checks for the SPI status block
// Assumes: One clock domain, asynchronous low reset
// Notes: A pin history stands in for the de-glitch delay
`timescale 1ns/1ps
`default_nettype none
`include "sscf_map.vh"
module sscf_port_props #(parameter [7:0] CFG_ADDR = `SSCF_ADDR_CFG) (
	// Register bus
	input wire logic clk, rst_n, sfr_wr, sfr_rd, sfr_bit_clr,
	input wire logic [3:0] sfr_page,
	input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q,
	// Request and select pin
	input wire logic irq_q, slave_select_line_in, slave_select_line_out_q,
	input wire logic slave_select_line_oe_n_q
);
	wire p0 = sfr_page == 4'h0;
	wire ctl = p0 && sfr_addr == `SSCF_ADDR_CTRL;
	wire cfg = p0 && sfr_addr == CFG_ADDR;
	wire dat = sfr_addr == `SSCF_ADDR_DATA || sfr_addr == `SSCF_ADDR_RATE;
	wire rdc = sfr_rd && cfg;
	wire wrc = sfr_wr && ctl;
	logic [11:0] hist_q;
	logic [1:0] clr_q;
	logic mst_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hist_q <= 12'hFFF;
			clr_q <= 2'h0;
			mst_q <= 1'b0;
		end else begin
			hist_q <= {hist_q[10:0], slave_select_line_in};
			clr_q <= {clr_q[0], ctl && (sfr_wr || sfr_bit_clr)};
			if (sfr_wr && cfg)
				mst_q <= sfr_wdata[6];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata_q))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (sfr_rd && !(ctl || cfg || p0 && dat) |=>
		sfr_rdata_q == 8'h00) else $error("unmapped read not zero");
	master_empty_a: assert property (rdc && mst_q |=> sfr_rdata_q[1:0] == 2'h3)
		else $error("master empty flags not one");
	raw_level_a: assert property (rdc && (hist_q[3:0] == 4'h0 || hist_q[3:0] == 4'hF)
		&& slave_select_line_in == hist_q[0] |=> sfr_rdata_q[2] == $past(hist_q[0]))
		else $error("raw select bit wrong");
	sel_flag_a: assert property (rdc && (hist_q == 12'h000 || hist_q == 12'hFFF) |=>
		sfr_rdata_q[3] == !$past(hist_q[0])) else $error("selected flag wrong");
	sel_drive_a: assert property (wrc && sfr_wdata[3:2] == 2'h2 && sfr_wdata[0] |->
		##[1:4] !slave_select_line_oe_n_q && !slave_select_line_out_q)
		else $error("select not driven low");
	sel_input_a: assert property (wrc && !sfr_wdata[3] |-> ##[1:4] slave_select_line_oe_n_q)
		else $error("select driven in input mode");
	irq_hold_a: assert property ($fell(irq_q) |-> |clr_q)
		else $error("request dropped without software clear");
	cover property ($rose(irq_q));
	cover property (rdc && hist_q == 12'h000);
	cover property (!slave_select_line_oe_n_q && !slave_select_line_out_q);
endmodule
bind sscf_port sscf_port_props #(.CFG_ADDR(CFG_ADDR)) u_props (.clk, .rst_n, .sfr_wr,
	.sfr_rd, .sfr_bit_clr, .sfr_page, .sfr_addr, .sfr_wdata, .sfr_rdata_q, .irq_q,
	.slave_select_line_in, .slave_select_line_out_q, .slave_select_line_oe_n_q);
`default_nettype wire

//--- bench/sscf_peer.sv
// Purpose: Behavioural SPI slave facing the port as master
// Assumes: Clock idles low, data changes on the falling edge
// Notes: Repeats one byte each frame; a released line shows the inverse
`timescale 1ns/1ps
`default_nettype none
module sscf_peer (
	// Serial side
	input wire logic sck,
	input wire logic sel_n,
	input wire logic [7:0] tx_byte,
	output logic miso
);
	logic [7:0] sr;
	initial miso = 1'b0;
	always @(negedge sel_n) begin
		sr = tx_byte;
		miso = tx_byte[7];
	end
	always @(negedge sck) begin
		if (!sel_n) begin
			sr = {sr[6:0], sr[7]};
			miso = sr[7];
		end
	end
	// No pull here, so a stale bit must not survive release
	always @(posedge sel_n) miso = ~miso;
endmodule
`default_nettype wire

//--- bench/test_spi_status_control_flags.sv
// Purpose: Self-checking bench of the SPI status block
// Assumes: Peer slave on the lines; bench is master in slave tests
// Notes: Slave traffic uses a 125 ns clock unrelated to clk
`timescale 1ns/1ps
`default_nettype none
`include "sscf_map.vh"
module test_spi_status_control_flags;
	logic clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_set = 1'b0;
	logic sfr_bit_clr = 1'b0, tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss = 1'b1, peer_miso;
	logic [3:0] sfr_page = 4'h0;
	logic [2:0] sfr_bit = 3'h0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rd_q, sfr_rdata_q;
	logic irq_q, sck_out_q, sck_oe_n_q, mosi_out_q, mosi_oe_n_q, miso_out_q, miso_oe_n_q;
	logic slave_select_line_out_q, slave_select_line_oe_n_q;
	int num_errors = 0, samples_checked = 0;
	wire sck_in = sck_oe_n_q ? tb_sck : sck_out_q;
	wire mosi_in = mosi_oe_n_q ? tb_mosi : mosi_out_q;
	wire miso_in = miso_oe_n_q ? peer_miso : miso_out_q;
	wire slave_select_line_in = slave_select_line_oe_n_q ? tb_ss : slave_select_line_out_q;
	sscf_port DUT (.clk, .rst_n, .sfr_page, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
		.sfr_bit_set, .sfr_bit_clr, .sfr_bit, .sfr_rdata_q, .irq_q, .sck_in, .sck_out_q,
		.sck_oe_n_q, .mosi_in, .mosi_out_q, .mosi_oe_n_q, .miso_in, .miso_out_q, .miso_oe_n_q,
		.slave_select_line_in, .slave_select_line_out_q, .slave_select_line_oe_n_q);
	sscf_peer peer (.sck(sck_in), .sel_n(slave_select_line_in), .tx_byte(8'h96), .miso(peer_miso));
	initial forever #2 clk = ~clk;
	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(negedge clk);
		rd_q = sfr_rdata_q;
	endtask
	task automatic bop(input logic s, input logic [2:0] b);
		@(posedge clk);
		sfr_addr <= `SSCF_ADDR_CTRL;
		sfr_bit <= b;
		sfr_bit_set <= s;
		sfr_bit_clr <= !s;
		@(posedge clk);
		sfr_bit_set <= 1'b0;
		sfr_bit_clr <= 1'b0;
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		// Let a just-cleared request fall before waiting on it
		repeat (3) @(posedge clk);
		while (irq_q !== 1'b1 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		if (n == 1000) begin
			num_errors++;
			give_verdict();
		end
	endtask
	task automatic sbyte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			tb_mosi = b[i];
			#62.5 tb_sck = 1'b1;
			#62.5 tb_sck = 1'b0;
		end
	endtask
	task automatic t_reset();
		rd(`SSCF_ADDR_CTRL);
		chk(rd_q, `SSCF_CTRL_RESET, "ctl");
		rd(`SSCF_ADDR_CFG);
		chk(rd_q, 8'h07, "cfg");
		rd(8'h00);
		chk(rd_q, 8'h00, "hole");
		bop(1'b1, 3'h0);
		rd(`SSCF_ADDR_CTRL);
		chk(rd_q, 8'h07, "bitset");
	endtask
	task automatic t_master();
		wr(`SSCF_ADDR_CFG, 8'h40);
		// Half bit of four clocks leaves room for the two-flop input delay
		wr(`SSCF_ADDR_RATE, 8'h03);
		wr(`SSCF_ADDR_CTRL, 8'h0B);
		rd(`SSCF_ADDR_CFG);
		chk(rd_q & 8'h43, 8'h43, "mst cfg");
		wr(`SSCF_ADDR_DATA, 8'h5A);
		repeat (4) @(posedge clk);
		wr(`SSCF_ADDR_DATA, 8'hC3);
		wr(`SSCF_ADDR_DATA, 8'h11);
		rd(`SSCF_ADDR_CTRL);
		chk(rd_q, 8'h49, "write_collision_flag");
		bop(1'b0, 3'h6);
		wait_irq();
		rd(`SSCF_ADDR_CTRL);
		chk(rd_q, 8'h8B, "done");
		bop(1'b0, 3'h7);
		wait_irq();
		rd(`SSCF_ADDR_DATA);
		chk(rd_q, 8'h96, "rx");
	endtask
	task automatic t_fault();
		wr(`SSCF_ADDR_CTRL, 8'h05);
		@(posedge clk);
		tb_ss <= 1'b0;
		repeat (20) @(posedge clk);
		rd(`SSCF_ADDR_CTRL);
		chk(rd_q & 8'h20, 8'h20, "mode_fault_flag");
		tb_ss <= 1'b1;
	endtask
	task automatic t_slave();
		wr(`SSCF_ADDR_CFG, 8'h00);
		wr(`SSCF_ADDR_CTRL, 8'h05);
		@(posedge clk);
		tb_ss <= 1'b0;
		repeat (20) @(posedge clk);
		rd(`SSCF_ADDR_CFG);
		chk(rd_q & 8'h0D, 8'h09, "sel");
		sbyte(8'hC3);
		repeat (20) @(posedge clk);
		rd(`SSCF_ADDR_CFG);
		chk(rd_q & 8'h03, 8'h02, "empties");
		sbyte(8'h3C);
		repeat (20) @(posedge clk);
		rd(`SSCF_ADDR_CTRL);
		chk(rd_q & 8'hF0, 8'h90, "ovrn");
		tb_ss <= 1'b1;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_master();
		t_fault();
		t_slave();
		give_verdict();
	end
endmodule
`default_nettype wire
